// ---- design/hicr_regs.sv ----
// Purpose: Host interface and application configuration register bank.
// Assumes: Registers are reached over the four-wire link or the internal
//          port of the two-wire engine; the image arrives once at boot.
// Notes:   Four-wire reads return the register named by the previous read.
`timescale 1ns/1ps
module hicr_regs
  import hicr_pkg::*;
#(
  parameter int STUCK_LIMIT = STUCK_CYCLES // Stuck clock limit in cycles
)
(
  input  wire logic        clk,                // Device clock
  input  wire logic        arst_n,             // Async reset, active low
  // Image load from one-time memory
  input  wire logic        otp_load,           // One-cycle load strobe
  input  hicr_image_s      otp_image,          // Image bytes
  // Internal register port of the two-wire engine
  input  wire logic        port_valid,         // Access request
  input  wire logic        port_write,         // 1 write, 0 read
  input  wire logic [8:0]  port_addr,          // Register address
  input  wire logic [7:0]  port_wdata,         // Write data
  output logic [7:0]       port_rdata,         // Read data, next cycle
  output logic             port_ack,           // Answer strobe
  // Four-wire link pins
  input  wire logic        serial_clock,       // Link clock
  input  wire logic        chip_select,        // Select
  input  wire logic        serial_data_in,     // Data from host
  output logic             serial_data_out,    // Data to host
  output logic             serial_data_oe,     // Data drive enable
  // Two-wire engine control
  output hicr_addr_s       bus_address,        // Answer bytes per page group
  output logic             interface_is_two_wire,
  output logic             pin_override,       // General pins taken over
  output logic             continuous_high_speed_en,
  output logic             fast_plus_timing_en,
  output logic             interface_supply_select,
  output logic             input_supply_select,
  output logic             two_wire_reset,     // One-cycle stuck reset
  // Interrupt pin
  input  wire logic        irq_request,        // Internal request level
  output logic             interrupt_output,   // Pin output value
  output logic             interrupt_oe,       // Pin drive enable
  // Supervision
  output logic             io_uvlo_enable,     // Io rail lockout active
  input  wire logic        conv_a_pg_raw,      // Converter A power good
  input  wire logic        conv_b_pg_raw,      // Converter B power good
  input  wire logic        conv_a_transition,  // A in voltage transition
  input  wire logic        conv_b_transition,  // B in voltage transition
  output logic             conv_a_pg,          // Filtered A power good
  output logic             conv_b_pg           // Filtered B power good
);

  // ********************
  // Register storage
  // ********************
  logic [7:0]   setup;        // host_interface_setup
  logic [7:0]   options;      // host_interface_options
  logic [7:0]   cfg_first;    // application_config_first
  logic [7:0]   cfg_second;   // application_config_second

  // Link crossing
  hicr_frame_s  link_frame;   // Held in link domain
  logic         link_tgl;     // Link frame toggle
  logic [2:0]   tgl_sync;     // Two stages plus edge history
  logic         link_event;   // One cycle per frame
  logic [7:0]   link_reply;   // Reply for the next read frame

  // Write selection
  logic         wr_en;
  logic [8:0]   wr_addr;
  logic [7:0]   wr_data;
  logic         link_pending; // Link access deferred by port
  hicr_frame_s  link_held;    // Frame waiting for service

  // Stuck clock watch
  logic [1:0]   sck_sync;     // Serial clock level synchroniser
  logic [31:0]  low_cnt;      // Cycles with clock low

  // Power good history
  logic         pg_a_hold;
  logic         pg_b_hold;

  // ********************
  // Read mux
  // ********************
  // Unmapped addresses and reserved bits read as zero
  function automatic logic [7:0] read_reg(input logic [8:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_SETUP)
    begin
      v = setup;
    end
    else if (a == ADDR_OPTIONS)
    begin
      v = options;
    end
    else if (a == ADDR_CFG_FST)
    begin
      v = cfg_first;
    end
    else if (a == ADDR_CFG_SND)
    begin
      v = cfg_second;
    end
    return v;
  endfunction

  // ********************
  // Four-wire receiver on the link clock
  // ********************
  hicr_link_rx u_link_rx
  (
    .arst_n          (arst_n),
    .serial_clock    (serial_clock),
    .chip_select     (chip_select),
    .serial_data_in  (serial_data_in),
    .cpol            (setup[BIT_CPOL]),
    .cpha            (setup[BIT_CPHA]),
    .select_pol      (setup[BIT_SEL_POL]),
    .dir_pol         (setup[BIT_DIR_POL]),
    .reply           (link_reply),
    .serial_data_out (serial_data_out),
    .serial_data_oe  (serial_data_oe),
    .frame           (link_frame),
    .frame_toggle    (link_tgl)
  );

  // Toggle synchroniser; the frame word is stable for a whole frame
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tgl_sync <= 3'h0;
    end
    else
    begin
      tgl_sync <= {tgl_sync[1:0], link_tgl};
    end
  end

  assign link_event = tgl_sync[2] ^ tgl_sync[1];

  // ********************
  // Access arbitration
  // ********************
  // The internal port wins; a link frame waits one free cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_pending <= 1'b0;
      link_held    <= '0;
    end
    else if (link_event)
    begin
      // Frame word is safe to read: it changes only a frame later
      link_pending <= 1'b1;
      link_held    <= link_frame;
    end
    else if (!port_valid)
    begin
      link_pending <= 1'b0;
    end
  end

  // Pick the write source for this cycle
  always_comb
  begin
    wr_en   = 1'b0;
    wr_addr = port_addr;
    wr_data = port_wdata;
    if (port_valid)
    begin
      wr_en = port_write;
    end
    else if (link_pending)
    begin
      wr_en   = !link_held.is_read;
      wr_addr = link_held.addr;
      wr_data = link_held.data;
    end
  end

  // ********************
  // Register writes and image load
  // ********************
  // Image load overrides software writes in the same cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      setup      <= RST_SETUP;
      options    <= RST_OPTIONS;
      cfg_first  <= RST_CFG_FST;
      cfg_second <= RST_CFG_SND;
    end
    else if (otp_load)
    begin
      setup      <= otp_image.setup & MASK_SETUP;
      options    <= otp_image.options & MASK_OPTIONS;
      cfg_first  <= otp_image.cfg_first & MASK_CFG_FST;
      cfg_second <= otp_image.cfg_second & MASK_CFG_SND;
    end
    else if (wr_en)
    begin
      if (wr_addr == ADDR_SETUP)
      begin
        setup <= wr_data & MASK_SETUP;
      end
      else if (wr_addr == ADDR_OPTIONS)
      begin
        options <= wr_data & MASK_OPTIONS;
      end
      else if (wr_addr == ADDR_CFG_FST)
      begin
        cfg_first <= wr_data & MASK_CFG_FST;
      end
      else if (wr_addr == ADDR_CFG_SND)
      begin
        cfg_second <= wr_data & MASK_CFG_SND;
      end
    end
  end

  // Internal port answer, one cycle after the request
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      port_rdata <= 8'h00;
      port_ack   <= 1'b0;
    end
    else
    begin
      port_ack <= port_valid;
      if (port_valid && !port_write)
      begin
        port_rdata <= read_reg(port_addr);
      end
    end
  end

  // Link reply; read once the frame is served, used by the next read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_reply <= 8'h00;
    end
    else if (link_pending && !port_valid && link_held.is_read)
    begin
      link_reply <= read_reg(link_held.addr);
    end
  end

  // ********************
  // Two-wire addressing
  // ********************
  logic [3:0] base_nibble;
  logic [7:0] base_byte;

  // Blank one-time memory still lets the host find the device
  assign base_nibble = (setup[7:4] == UNPROGRAMMED) ? HW_BASE_NIBBLE
                                                     : setup[7:4];
  assign base_byte   = {base_nibble, 4'h0};

  // Registered so the engine sees clean address compares
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_address <= '0;
    end
    else
    begin
      bus_address.wr_p01 <= base_byte + OFS_WR_P01;
      bus_address.rd_p01 <= base_byte + OFS_RD_P01;
      bus_address.wr_p23 <= base_byte + OFS_WR_P23;
      bus_address.rd_p23 <= base_byte + OFS_RD_P23;
      bus_address.rd_p45 <= base_byte + OFS_RD_P45;
    end
  end

  // ********************
  // Interface mode controls
  // ********************
  assign interface_is_two_wire    = options[BIT_IF_TWO];
  assign pin_override             = !options[BIT_IF_TWO];
  assign continuous_high_speed_en = options[BIT_HS_EN];
  assign fast_plus_timing_en      = options[BIT_FMP_EN];
  assign interface_supply_select  = options[BIT_SUPPLY];
  assign input_supply_select      = cfg_first[BIT_IN_SUPPLY];

  // ********************
  // Stuck clock timeout
  // ********************
  // Level synchroniser; only the second stage is read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sck_sync <= 2'h3;
    end
    else
    begin
      sck_sync <= {sck_sync[0], serial_clock};
    end
  end

  // Count low time; fire once, then wait for the clock to rise
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_cnt        <= 32'h0;
      two_wire_reset <= 1'b0;
    end
    else
    begin
      two_wire_reset <= 1'b0;
      if (sck_sync[1] || !cfg_first[BIT_TO_EN] || !options[BIT_IF_TWO])
      begin
        low_cnt <= 32'h0;
      end
      else if (low_cnt <= 32'(STUCK_LIMIT))
      begin
        low_cnt <= low_cnt + 32'h1;
        if (low_cnt == 32'(STUCK_LIMIT))
        begin
          two_wire_reset <= 1'b1;
        end
      end
    end
  end

  // ********************
  // Interrupt pin
  // ********************
  // Open drain can only pull low, so it is enabled only for that level
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      interrupt_output <= 1'b1;
      interrupt_oe     <= 1'b1;
    end
    else if (cfg_first[BIT_IRQ_OD])
    begin
      interrupt_output <= 1'b0;
      interrupt_oe     <= irq_request ^ cfg_first[BIT_IRQ_HIGH];
    end
    else
    begin
      interrupt_output <= ~(irq_request ^ cfg_first[BIT_IRQ_HIGH]);
      interrupt_oe     <= 1'b1;
    end
  end

  // ********************
  // Supervision
  // ********************
  assign io_uvlo_enable = !cfg_second[BIT_UVLO_DIS];

  // Power good follows the converter, or freezes during a transition when its mask bit is set
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pg_a_hold <= 1'b0;
      pg_b_hold <= 1'b0;
    end
    else
    begin
      if (!(cfg_second[BIT_PGA_MASK] && conv_a_transition))
      begin
        pg_a_hold <= conv_a_pg_raw;
      end
      if (!(cfg_second[BIT_PGB_MASK] && conv_b_transition))
      begin
        pg_b_hold <= conv_b_pg_raw;
      end
    end
  end

  assign conv_a_pg = pg_a_hold;
  assign conv_b_pg = pg_b_hold;

endmodule // hicr_regs

// ---- design/hicr_pkg.sv ----
// Purpose: Constants and carrier types of the config register bank.
// Assumes: 100 MHz device clock; 8-bit registers.
// Notes:   Functional notes follow.
// Functional notes
// - Setup bits 7:4 give upper address nibble
// - Pages 0-1 answer at base, base+1
// - Pages 2-3 answer at base+2, base+3
// - Pages 4-5 read at base+5
// - Zero nibble falls back to hardware default
// - Setup bit 3 sets four-wire read marker
// - Setup bit 2 sets four-wire clock phase
// - Setup bit 1 sets serial clock idle level
// - Setup bit 0 sets chip select polarity
// - Options bit 7 chooses two-wire or four-wire
// - Options bit 6 enables continuous high speed
// - Options bit 5 enables fast plus timing
// - Stuck low clock over 35 ms resets interface
// - Config bit 1 picks open drain interrupt
// - Config bit 0 picks interrupt active level
// - Config bit 7 disables io rail lockout
// - Bit 6 holds converter B power-good in transitions
// - Bit 5 holds converter A power-good in transitions

package hicr_pkg;

  // ********************
  // Register map
  // ********************
  localparam logic [8:0] ADDR_SETUP    = 9'h105; // host_interface_setup
  localparam logic [8:0] ADDR_OPTIONS  = 9'h106; // host_interface_options
  localparam logic [8:0] ADDR_CFG_FST  = 9'h143; // application_config_first
  localparam logic [8:0] ADDR_CFG_SND  = 9'h144; // application_config_second

  // Reset values, used until the one-time memory image arrives
  localparam logic [7:0] RST_SETUP     = 8'h00;
  localparam logic [7:0] RST_OPTIONS   = 8'h80;
  localparam logic [7:0] RST_CFG_FST   = 8'h00;
  localparam logic [7:0] RST_CFG_SND   = 8'h00;

  // Implemented bits per register; the rest read as zero
  localparam logic [7:0] MASK_SETUP    = 8'hff;
  localparam logic [7:0] MASK_OPTIONS  = 8'hf0;
  localparam logic [7:0] MASK_CFG_FST  = 8'h1b;
  localparam logic [7:0] MASK_CFG_SND  = 8'he0;

  // ********************
  // Field positions
  // ********************
  localparam int BIT_DIR_POL   = 3; // Read marker
  localparam int BIT_CPHA      = 2; // Clock phase
  localparam int BIT_CPOL      = 1; // Idle level
  localparam int BIT_SEL_POL   = 0; // Select level
  localparam int BIT_IF_TWO    = 7; // Two-wire
  localparam int BIT_HS_EN     = 6; // High speed
  localparam int BIT_FMP_EN    = 5; // Fast plus
  localparam int BIT_SUPPLY    = 4; // Bus supply
  localparam int BIT_TO_EN     = 4; // Timeout
  localparam int BIT_IN_SUPPLY = 3; // Input supply
  localparam int BIT_IRQ_OD    = 1; // Open drain
  localparam int BIT_IRQ_HIGH  = 0; // Active high
  localparam int BIT_UVLO_DIS  = 7; // No io lockout
  localparam int BIT_PGB_MASK  = 6; // B mask
  localparam int BIT_PGA_MASK  = 5; // A mask

  // Two-wire address offsets from the base byte
  localparam logic [7:0] OFS_WR_P01    = 8'h00;
  localparam logic [7:0] OFS_RD_P01    = 8'h01;
  localparam logic [7:0] OFS_WR_P23    = 8'h02;
  localparam logic [7:0] OFS_RD_P23    = 8'h03;
  localparam logic [7:0] OFS_RD_P45    = 8'h05;
  localparam logic [3:0] HW_BASE_NIBBLE = 4'hd; // Hardware default base
  localparam logic [3:0] UNPROGRAMMED  = 4'h0;

  // ********************
  // Timing
  // ********************
  localparam int CLK_KHZ        = 100000;
  localparam int STUCK_TIME_MS  = 35;
  localparam int STUCK_CYCLES   = STUCK_TIME_MS * CLK_KHZ;

  // Four-wire frame: 1 direction bit, 6 pad, 9 address, 8 data
  localparam int FRAME_BITS     = 24;
  localparam int HEAD_BITS      = 16;

  // ********************
  // Carrier types
  // ********************
  typedef struct packed {
    logic       is_read;
    logic [8:0] addr;
    logic [7:0] data;
  } hicr_frame_s;

  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] options;
    logic [7:0] cfg_first;
    logic [7:0] cfg_second;
  } hicr_image_s;

  typedef struct packed {
    logic [7:0] wr_p01;
    logic [7:0] rd_p01;
    logic [7:0] wr_p23;
    logic [7:0] rd_p23;
    logic [7:0] rd_p45;
  } hicr_addr_s;

endpackage

// ---- design/hicr_link_rx.sv ----
// Purpose: Four-wire frame receiver on the serial clock domain.
// Assumes: Mode inputs are static while a frame is in progress.
// Notes:   Holds the last frame until the next one completes.
`timescale 1ns/1ps
module hicr_link_rx
  import hicr_pkg::*;
(
  input  wire logic        arst_n,         // Device reset, active low
  input  wire logic        serial_clock,   // Link clock pin
  input  wire logic        chip_select,    // Select pin
  input  wire logic        serial_data_in, // Host to device data
  input  wire logic        cpol,           // Idle level of clock
  input  wire logic        cpha,           // Clock phase
  input  wire logic        select_pol,     // Select polarity
  input  wire logic        dir_pol,        // Value marking a read
  input  wire logic [7:0]  reply,          // Quasi-static read reply
  output logic             serial_data_out,// Device to host data
  output logic             serial_data_oe, // Drive enable for data out
  output hicr_frame_s      frame,          // Last completed frame
  output logic             frame_toggle    // Flips per completed frame
);

  // ********************
  // Clocking
  // ********************
  logic       sel_act;   // Select asserted
  logic       shift_clk; // Sampling clock
  logic       frame_rst_n;
  logic [4:0] bit_cnt;   // Bits sampled so far
  logic [22:0] shreg;    // Incoming bits
  logic       is_read;   // Direction of this frame

  // Mode change during a frame glitches the clock; config is static
  assign sel_act     = chip_select ^ ~select_pol;
  // Sample edge rises for modes (0,0) and (1,1)
  assign shift_clk   = serial_clock ^ (cpol ^ cpha);
  // Bit state clears between frames without needing a clock edge
  assign frame_rst_n = arst_n & sel_act;

  // Shift in data and count bits on each sampling edge
  always_ff @(posedge shift_clk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_cnt <= 5'h00;
      shreg   <= 23'h000000;
      is_read <= 1'b0;
    end
    else if (bit_cnt != 5'(FRAME_BITS))
    begin
      bit_cnt <= bit_cnt + 5'h01;
      shreg   <= {shreg[21:0], serial_data_in};
      if (bit_cnt == 5'h00)
      begin
        is_read <= (serial_data_in == dir_pol);
      end
    end
  end

  // Publish the completed frame; survives the select release
  always_ff @(posedge shift_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frame        <= '0;
      frame_toggle <= 1'b0;
    end
    else if (sel_act && bit_cnt == 5'(FRAME_BITS - 1))
    begin
      frame.is_read <= is_read;
      frame.addr    <= shreg[15:7];
      frame.data    <= {shreg[6:0], serial_data_in};
      frame_toggle  <= ~frame_toggle;
    end
  end

  // Drive reply bits on the opposite edge, most significant first
  always_ff @(negedge shift_clk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      serial_data_out <= 1'b0;
    end
    else if (bit_cnt >= 5'(HEAD_BITS) && bit_cnt < 5'(FRAME_BITS))
    begin
      serial_data_out <= reply[3'(5'(FRAME_BITS - 1) - bit_cnt)];
    end
  end

  assign serial_data_oe = sel_act && is_read && (bit_cnt >= 5'(HEAD_BITS));

endmodule // hicr_link_rx

// ---- bench/hicr_checker.sv ----
// Purpose: Port assertions for the configuration register bank
// Assumes: One device clock domain; image load beats a port write
// Notes:   Bound into every hicr_regs instance
`timescale 1ns/1ps
module hicr_checker
  import hicr_pkg::*;
(
  input wire logic       clk, arst_n, otp_load, port_valid, port_write,
  input wire logic [8:0] port_addr,
  input wire logic [7:0] port_wdata,
  input hicr_addr_s      bus_address,
  input wire logic       interface_is_two_wire, pin_override, continuous_high_speed_en,
  input wire logic       fast_plus_timing_en, two_wire_reset, io_uvlo_enable,
  input wire logic       conv_a_pg_raw, conv_b_pg_raw, conv_a_transition,
  input wire logic       conv_b_transition, conv_a_pg, conv_b_pg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic       wr;   // Port write that takes effect
  logic [7:0] wd_q; // Write data of the previous cycle
  assign wr = port_valid && port_write && !otp_load;
  // Keeps the write byte so a later cycle can compare single fields
  always_ff @(posedge clk) wd_q <= port_wdata;

  AST_BASE:
    assert property ($past(arst_n) |-> bus_address.wr_p01[3:0] == 4'h0 &&
      bus_address.wr_p01[7:4] != 4'h0) else $error("base byte wrong");
  AST_PAGES:
    assert property ($past(arst_n) |-> {bus_address.rd_p01, bus_address.wr_p23, bus_address.rd_p23,
      bus_address.rd_p45} == ({4{bus_address.wr_p01}} | 32'h01020305)) else $error("page byte");
  AST_TYPE:
    assert property (wr && port_addr == ADDR_OPTIONS |=> interface_is_two_wire == wd_q[7]
      && pin_override != interface_is_two_wire) else $error("interface type");
  AST_SPEED:
    assert property (wr && port_addr == ADDR_OPTIONS |=> {continuous_high_speed_en,
      fast_plus_timing_en} == wd_q[6:5]) else $error("speed bits");
  AST_UVLO:
    assert property (wr && port_addr == ADDR_CFG_SND |=> io_uvlo_enable != wd_q[7])
      else $error("lockout enable");
  AST_PGA:
    assert property (!conv_a_transition |=> conv_a_pg == $past(conv_a_pg_raw)) else $error("pg a");
  AST_PGB:
    assert property (!conv_b_transition |=> conv_b_pg == $past(conv_b_pg_raw)) else $error("pg b");
  AST_STUCK:
    assert property (two_wire_reset |-> interface_is_two_wire ##1 !two_wire_reset)
      else $error("stuck reset pulse");
endmodule // hicr_checker

bind hicr_regs hicr_checker i_hicr_checker (.*);

// ---- bench/hicr_host.sv ----
// Purpose: Host end of the four-wire link
// Assumes: Mode inputs mirror the setup register
// Notes:   Clock stands at its idle level between frames
`timescale 1ns/1ps
module hicr_host
(
  input  wire logic cpol,
  input  wire logic cpha,
  input  wire logic sel_pol,
  input  wire logic dir_pol,
  input  wire logic sdo,
  output logic      sck,
  output logic      csel,
  output logic      sdi
);
  initial {sck, csel, sdi} = 3'b010;
  // Parks the clock, used to hold it low for the stuck test
  task automatic park(input logic l);
    sck = l;
  endtask
  // One frame MSB first; q keeps the last eight bits seen
  task automatic xfer(input logic rd, input logic [8:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [23:0] f;
    f = {rd ~^ dir_pol, 6'h00, a, d};
    {sck, csel} = {cpol, !sel_pol};
    #48 csel = sel_pol;
    for (int i = 23; i >= 0; i--)
    begin
      if (!cpha) sdi = f[i];
      #24 sck = !sck;
      if (cpha) sdi = f[i]; else q = {q[6:0], sdo};
      #24 sck = !sck;
      if (cpha) q = {q[6:0], sdo};
    end
    // Released line shows the inverse, not a stale bit
    #24 {csel, sdi} = {!sel_pol, !sdi};
    #100;
  endtask
endmodule // hicr_host

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Stuck limit shortened to 50 device cycles
// Notes:   Four-wire traffic comes from the host model
`timescale 1ns/1ps
module tb;
  import hicr_pkg::*;
  localparam logic [8:0] ADR [5] =
    '{ADDR_SETUP, ADDR_OPTIONS, ADDR_CFG_FST, ADDR_CFG_SND, 9'h107};
  logic clk, arst_n, otp_load, port_valid, port_write, port_ack, irq_request, ea, eb;
  logic serial_clock, chip_select, serial_data_in, serial_data_out, serial_data_oe;
  logic interface_is_two_wire, pin_override, continuous_high_speed_en, fast_plus_timing_en;
  logic interface_supply_select, input_supply_select, two_wire_reset, io_uvlo_enable;
  logic interrupt_output, interrupt_oe, conv_a_pg, conv_b_pg;
  logic conv_a_pg_raw, conv_b_pg_raw, conv_a_transition, conv_b_transition;
  logic [8:0]  port_addr;
  logic [7:0]  port_wdata, port_rdata, su, q, d;
  logic [7:0]  mdl [512]; // Expected contents by address
  hicr_image_s otp_image;
  hicr_addr_s  bus_address;
  int          error_cnt, samples_checked, n;

  hicr_regs #(.STUCK_LIMIT(50)) i_hicr_regs (.*);
  hicr_host i_hicr_host (.cpol(su[1]), .cpha(su[2]), .sel_pol(su[0]), .dir_pol(su[3]),
    .sdo(serial_data_out), .sck(serial_clock), .csel(chip_select), .sdi(serial_data_in));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  // Hang guard
  initial
  begin
    #1000000 error_cnt++;
    conclude();
  end

  task automatic chk(input string s, input logic [7:0] x, input logic [7:0] y);
    samples_checked++;
    if (x !== y)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", s, x, y);
    end
  endtask
  function automatic logic [7:0] msk(input logic [8:0] a);
    case (a)
      ADDR_SETUP:   return MASK_SETUP;
      ADDR_OPTIONS: return MASK_OPTIONS;
      ADDR_CFG_FST: return MASK_CFG_FST;
      ADDR_CFG_SND: return MASK_CFG_SND;
      default:      return 8'h00;
    endcase
  endfunction
  // One port access from a falling edge; a free cycle parts two calls
  task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] x);
    @(negedge clk);
    {port_valid, port_write, port_addr, port_wdata} = {1'b1, w, a, x};
    @(negedge clk);
    port_valid = 1'b0;
    chk("ack", 8'h01, {7'h00, port_ack});
    if (w) mdl[a] = x & msk(a); else chk("rdata", mdl[a], port_rdata);
    su = mdl[ADDR_SETUP];
  endtask
  task automatic rd_all();
    logic [3:0] nb;
    foreach (ADR[k]) acc(1'b0, ADR[k], 8'h00);
    @(negedge clk);
    nb = (su[7:4] == 4'h0) ? HW_BASE_NIBBLE : su[7:4];
    chk("wr01", {nb, 4'h0}, bus_address.wr_p01);
    chk("rd01", {nb, 4'h1}, bus_address.rd_p01);
    chk("wr23", {nb, 4'h2}, bus_address.wr_p23);
    chk("rd23", {nb, 4'h3}, bus_address.rd_p23);
    chk("rd45", {nb, 4'h5}, bus_address.rd_p45);
    d = {mdl[ADDR_OPTIONS][7:5], mdl[ADDR_OPTIONS][7], mdl[ADDR_CFG_SND][7], 3'h0};
    q = {interface_is_two_wire, continuous_high_speed_en, fast_plus_timing_en,
         !pin_override, !io_uvlo_enable, 3'h0};
    chk("mode", d, q);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    {arst_n, otp_load, port_valid, port_write, irq_request, ea, eb} = '0;
    {conv_a_pg_raw, conv_b_pg_raw, conv_a_transition, conv_b_transition} = '0;
    {port_addr, port_wdata, otp_image, su} = '0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[ADDR_OPTIONS] = RST_OPTIONS;
    void'($urandom(88));
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    rd_all();
    repeat (4)
    begin
      foreach (ADR[k]) acc(1'b1, ADR[k], 8'($urandom));
      rd_all();
    end
    // Image load in the same cycle as a port write must win
    otp_image = hicr_image_s'($urandom);
    {otp_load, port_valid, port_write, port_addr} = {3'b111, ADDR_SETUP};
    @(negedge clk);
    {otp_load, port_valid} = 2'b00;
    {mdl[ADDR_SETUP], mdl[ADDR_OPTIONS], mdl[ADDR_CFG_FST], mdl[ADDR_CFG_SND]} =
      otp_image & {MASK_SETUP, MASK_OPTIONS, MASK_CFG_FST, MASK_CFG_SND};
    rd_all();
    // Every four-wire mode: link write, then two pipelined reads
    acc(1'b1, ADDR_OPTIONS, 8'h00);
    for (int m = 0; m < 16; m++)
    begin
      acc(1'b1, ADDR_SETUP, {4'h0, m[3:0]});
      d = 8'($urandom);
      i_hicr_host.xfer(1'b0, ADDR_CFG_FST, d, q);
      mdl[ADDR_CFG_FST] = d & MASK_CFG_FST;
      i_hicr_host.xfer(1'b1, ADDR_CFG_FST, 8'h00, q);
      i_hicr_host.xfer(1'b1, ADDR_SETUP, 8'h00, q);
      chk("link", mdl[ADDR_CFG_FST], q);
      acc(1'b0, ADDR_CFG_FST, 8'h00);
    end
    // Interrupt pin in each drive style and active level
    for (int m = 0; m < 8; m++)
    begin
      acc(1'b1, ADDR_CFG_FST, {6'h00, m[1:0]});
      irq_request = m[2];
      repeat (3) @(negedge clk);
      d = {6'h00, m[1] ? 1'b0 : m[2] ~^ m[0], m[1] ? m[2] ^ m[0] : 1'b1};
      chk("irq", d, {6'h00, interrupt_output & interrupt_oe, interrupt_oe});
    end
    // Power good under each mask setting with random transitions
    for (int m = 0; m < 4; m++)
    begin
      acc(1'b1, ADDR_CFG_SND, {1'b0, m[1:0], 5'h00});
      for (int c = 0; c < 40; c++)
      begin
        {conv_a_pg_raw, conv_b_pg_raw} = 2'($urandom);
        {conv_b_transition, conv_a_transition} = (c < 2) ? 2'b00 : 2'($urandom);
        @(negedge clk);
        if (!(m[0] && conv_a_transition)) ea = conv_a_pg_raw;
        if (!(m[1] && conv_b_transition)) eb = conv_b_pg_raw;
        chk("pg", {6'h00, ea, eb}, {6'h00, conv_a_pg, conv_b_pg});
      end
    end
    // Stuck clock: one reset pulse only when the timeout is enabled
    for (int m = 0; m < 2; m++)
    begin
      acc(1'b1, ADDR_OPTIONS, 8'h80);
      acc(1'b1, ADDR_CFG_FST, {3'h0, m[0], 4'h0});
      i_hicr_host.park(1'b0);
      n = 0;
      repeat (120) @(negedge clk) n += two_wire_reset;
      i_hicr_host.park(1'b1);
      chk("stuck", {7'h00, m[0]}, 8'(n));
    end
    conclude();
  end
endmodule // tb
